/* File: src/fdcd_pkg.sv */
// Constants and carrier types for the floppy command-set decoder.
// Assumes a 125 MHz core clock and one host command/result byte port.
package fdcd_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned STEP_UNIT_US = 1000;
    localparam int unsigned STEP_UNIT_CYC = STEP_UNIT_US * CLK_MHZ;
    localparam int unsigned TMR_W = 24;
    localparam logic [7:0] OP_SEEK = 8'h0f;
    localparam logic [7:0] OP_SENSE_DRV = 8'h04;
    localparam logic [7:0] OP_SENSE_INT = 8'h08;
    localparam logic [7:0] OP_SPECIFY = 8'h03;
    localparam logic [7:0] OP_VERSION = 8'h10;
    localparam logic [4:0] OP_SCAN_HE = 5'h1d;
    localparam logic [4:0] OP_SCAN_LE = 5'h19;
    localparam logic [4:0] OP_VERIFY = 5'h16;
    localparam logic [6:0] OP_SET_TRACK = 7'h21;
    localparam logic [5:0] OP_WRITE = 6'h05;
    localparam logic [5:0] OP_WRITE_DEL = 6'h09;
    localparam logic [7:0] ST0_INVALID = 8'h80;
    localparam logic [7:0] ST0_SEEK_END = 8'h20;
    localparam logic [3:0] DATA_PARAMS = 4'h8;
    localparam logic [3:0] DATA_RESULTS = 4'h7;
    localparam logic [15:0] TRACK_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // Arbitrary neutral revision value
    localparam logic [7:0] VERSION_DEFAULT = 8'h5a;

    typedef enum logic [3:0] {
        K_SCAN_HE, K_SCAN_LE, K_SEEK, K_SENSE_DRV, K_SENSE_INT, K_SET_TRACK,
        K_SPECIFY, K_VERIFY, K_VERSION, K_WRITE, K_WRITE_DEL, K_INVALID
    } fdcd_kind_type;

    typedef struct packed {
        fdcd_kind_type kind;
        logic multi_track_flag;
        logic double_density_select;
        logic skip_deleted_flag;
        logic [7:0][7:0] param;
    } fdcd_exec_type;

    typedef struct packed {
        logic [6:0][7:0] bytes;
    } fdcd_result_type;

    typedef struct packed {
        logic [3:0] step_rate;
        logic [3:0] motor_off;
        logic [6:0] motor_on;
        logic dma_bit;
    } fdcd_timing_type;
endpackage

/* File: src/fdcd_decoder.sv */
// Command decoder and phase sequencer for part of a floppy controller.
// Assumes host strobes and execution engine run on core_clk.
`timescale 1ns/1ps
module fdcd_decoder
    import fdcd_pkg::*;
#(
    parameter int unsigned STEP_UNIT_CYCLES = STEP_UNIT_CYC,
    parameter logic [7:0] VERSION_CODE = VERSION_DEFAULT
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic host_wr,
    input wire logic [7:0] host_wdata,
    input wire logic host_rd,
    input wire logic extended_track_range,
    input wire logic [3:0][7:0] drive_status,
    input wire logic exec_done,
    input wire fdcd_result_type exec_result,
    output logic busy_q,
    output logic res_valid_q,
    output logic [7:0] res_data_q,
    output logic exec_req_q,
    output fdcd_exec_type exec_cmd_q,
    output logic double_density_select_q,
    output fdcd_timing_type timing_q,
    output logic [1:0] drive_sel_q,
    output logic head_select_q,
    output logic step_q,
    output logic step_dir_q
);
    // ------------------------------------------------------------
    // Opcode decode
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE, S_PARAM, S_DISP, S_EXEC, S_SEEK, S_RESULT
    } fdcd_state_type;

    fdcd_state_type state_q;
    logic [3:0] pcnt_q;
    logic [3:0] need_q;
    logic [2:0] ridx_q;
    logic [3:0] rtot_q;
    logic [6:0][7:0] res_q;
    logic [3:0][15:0] trk_q;
    logic [11:0] target_q;
    logic [TMR_W-1:0] tmr_q;
    logic int_pend_q;
    logic [7:0] last_st0_q;
    logic [1:0] last_drv_q;

    wire is_seek = host_wdata == OP_SEEK;
    wire is_sdrv = host_wdata == OP_SENSE_DRV;
    wire is_sint = host_wdata == OP_SENSE_INT;
    wire is_spec = host_wdata == OP_SPECIFY;
    wire is_ver = host_wdata == OP_VERSION;
    wire is_she = host_wdata[4:0] == OP_SCAN_HE;
    wire is_sle = host_wdata[4:0] == OP_SCAN_LE;
    wire is_vfy = host_wdata[4:0] == OP_VERIFY;
    wire is_strk = host_wdata[7] == 1'b0 && host_wdata[5:0] == OP_SET_TRACK[5:0];
    wire is_wr = host_wdata[5:0] == OP_WRITE;
    wire is_wdel = host_wdata[5:0] == OP_WRITE_DEL;

    wire fdcd_kind_type kind_dec =
        is_seek ? K_SEEK :
        is_sdrv ? K_SENSE_DRV :
        is_sint ? K_SENSE_INT :
        is_spec ? K_SPECIFY :
        is_ver ? K_VERSION :
        is_strk ? K_SET_TRACK :
        is_she ? K_SCAN_HE :
        is_sle ? K_SCAN_LE :
        is_vfy ? K_VERIFY :
        is_wr ? K_WRITE :
        is_wdel ? K_WRITE_DEL :
        K_INVALID;

    // Parameter byte count per command
    wire [3:0] need_dec =
        (kind_dec == K_SEEK) ? (extended_track_range ? 4'h3 : 4'h2) :
        (kind_dec == K_SENSE_DRV) ? 4'h1 :
        (kind_dec == K_SET_TRACK) ? 4'h2 :
        (kind_dec == K_SPECIFY) ? 4'h2 :
        (kind_dec == K_SENSE_INT || kind_dec == K_VERSION || kind_dec == K_INVALID) ? 4'h0 :
        DATA_PARAMS;

    wire is_data = exec_cmd_q.kind == K_SCAN_HE || exec_cmd_q.kind == K_SCAN_LE ||
        exec_cmd_q.kind == K_VERIFY || exec_cmd_q.kind == K_WRITE ||
        exec_cmd_q.kind == K_WRITE_DEL;

    // ------------------------------------------------------------
    // Parameter fields
    // ------------------------------------------------------------
    wire [1:0] p_drv = exec_cmd_q.param[0][1:0];
    wire p_head = exec_cmd_q.param[0][2];
    wire p_hi = exec_cmd_q.param[0][2];
    wire p_rnw = exec_cmd_q.kind == K_SET_TRACK && exec_cmd_q.multi_track_flag;
    wire [3:0] p_nib = extended_track_range ? exec_cmd_q.param[2][7:4] : 4'h0;
    wire [15:0] sel_trk = trk_q[p_drv];
    wire [7:0] sel_half = p_hi ? sel_trk[15:8] : sel_trk[7:0];
    wire [15:0] last_trk = trk_q[last_drv_q];
    wire [11:0] cur_trk = trk_q[drive_sel_q][11:0];
    wire at_target = cur_trk == target_q;
    wire step_in = target_q > cur_trk;
    // A step rate field of zero gives the slowest rate, sixteen units
    wire [4:0] srt_fac = 5'h10 - {1'b0, timing_q.step_rate};
    wire [TMR_W-1:0] step_reload = TMR_W'(srt_fac * STEP_UNIT_CYCLES);
    wire res_last = {1'b0, ridx_q} == rtot_q - 4'h1;
    wire pop = state_q == S_RESULT && res_valid_q && host_rd;

    // ------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= S_IDLE;
            pcnt_q <= 4'h0;
            need_q <= 4'h0;
            ridx_q <= 3'h0;
            rtot_q <= 4'h0;
            res_q <= '0;
            trk_q <= {4{TRACK_RST}};
            target_q <= 12'h000;
            tmr_q <= '0;
            int_pend_q <= 1'b0;
            last_st0_q <= BYTE_RST;
            last_drv_q <= 2'h0;
            busy_q <= 1'b0;
            res_valid_q <= 1'b0;
            res_data_q <= BYTE_RST;
            exec_req_q <= 1'b0;
            exec_cmd_q <= '0;
            drive_sel_q <= 2'h0;
            head_select_q <= 1'b0;
            step_q <= 1'b0;
            step_dir_q <= 1'b0;
        end else begin
            step_q <= 1'b0;
            busy_q <= state_q != S_IDLE;
            case (state_q)
                S_IDLE: begin
                    if (host_wr) begin
                        exec_cmd_q.kind <= kind_dec;
                        exec_cmd_q.multi_track_flag <= host_wdata[7];
                        exec_cmd_q.double_density_select <= host_wdata[6];
                        exec_cmd_q.skip_deleted_flag <= host_wdata[5];
                        // Set track keeps its read_not_write bit in the flag slot
                        if (kind_dec == K_SET_TRACK) begin
                            exec_cmd_q.multi_track_flag <= host_wdata[6];
                        end
                        exec_cmd_q.param <= '0;
                        need_q <= need_dec;
                        pcnt_q <= 4'h0;
                        state_q <= (need_dec == 4'h0) ? S_DISP : S_PARAM;
                    end
                end
                S_PARAM: begin
                    if (host_wr) begin
                        exec_cmd_q.param[pcnt_q[2:0]] <= host_wdata;
                        pcnt_q <= pcnt_q + 4'h1;
                        if (pcnt_q == need_q - 4'h1) begin
                            state_q <= S_DISP;
                        end
                    end
                end
                S_DISP: begin
                    ridx_q <= 3'h0;
                    res_q <= '0;
                    drive_sel_q <= p_drv;
                    head_select_q <= p_head;
                    rtot_q <= 4'h1;
                    state_q <= S_RESULT;
                    case (exec_cmd_q.kind)
                        K_SCAN_HE, K_SCAN_LE, K_VERIFY, K_WRITE, K_WRITE_DEL: begin
                            exec_req_q <= 1'b1;
                            state_q <= S_EXEC;
                        end
                        K_SEEK: begin
                            target_q <= {p_nib, exec_cmd_q.param[1]};
                            tmr_q <= '0;
                            state_q <= S_SEEK;
                        end
                        K_SENSE_DRV: begin
                            res_q[0] <= drive_status[p_drv];
                        end
                        K_SENSE_INT: begin
                            if (int_pend_q) begin
                                res_q[0] <= last_st0_q;
                                res_q[1] <= last_trk[7:0];
                                res_q[2] <= {last_trk[11:8], 4'h0};
                                rtot_q <= extended_track_range ? 4'h3 : 4'h2;
                                int_pend_q <= 1'b0;
                            end else begin
                                res_q[0] <= ST0_INVALID;
                            end
                        end
                        K_SET_TRACK: begin
                            if (p_rnw) begin
                                res_q[0] <= sel_half;
                            end else begin
                                res_q[0] <= exec_cmd_q.param[1];
                                if (p_hi) begin
                                    trk_q[p_drv][15:8] <= exec_cmd_q.param[1];
                                end else begin
                                    trk_q[p_drv][7:0] <= exec_cmd_q.param[1];
                                end
                            end
                        end
                        K_SPECIFY: begin
                            state_q <= S_IDLE;
                        end
                        K_VERSION: begin
                            res_q[0] <= VERSION_CODE;
                        end
                        default: begin
                            res_q[0] <= ST0_INVALID;
                        end
                    endcase
                end
                S_EXEC: begin
                    if (exec_done) begin
                        res_q <= exec_result.bytes;
                        rtot_q <= DATA_RESULTS;
                        exec_req_q <= 1'b0;
                        state_q <= S_RESULT;
                    end
                end
                S_SEEK: begin
                    if (tmr_q != '0) begin
                        tmr_q <= tmr_q - TMR_W'(1);
                    end else if (at_target) begin
                        int_pend_q <= 1'b1;
                        last_st0_q <= ST0_SEEK_END | {5'h00, head_select_q, drive_sel_q};
                        last_drv_q <= drive_sel_q;
                        state_q <= S_IDLE;
                    end else begin
                        step_q <= 1'b1;
                        step_dir_q <= step_in;
                        trk_q[drive_sel_q][11:0] <= step_in ? cur_trk + 12'h001 :
                            cur_trk - 12'h001;
                        tmr_q <= step_reload;
                    end
                end
                S_RESULT: begin
                    // Valid drops for a cycle after each pop, so one strobe takes one byte
                    res_valid_q <= !pop;
                    res_data_q <= res_q[ridx_q];
                    if (pop) begin
                        ridx_q <= ridx_q + 3'h1;
                        if (res_last) begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Mode registers
    // ------------------------------------------------------------
    wire load_timing = state_q == S_DISP && exec_cmd_q.kind == K_SPECIFY;
    wire load_density = state_q == S_DISP && is_data;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            timing_q <= '0;
        end else if (load_timing) begin
            timing_q.step_rate <= exec_cmd_q.param[0][7:4];
            timing_q.motor_off <= exec_cmd_q.param[0][3:0];
            timing_q.motor_on <= exec_cmd_q.param[1][7:1];
            timing_q.dma_bit <= exec_cmd_q.param[1][0];
        end
    end

    // Encoding choice persists until the next data command
    always_ff @(posedge core_clk) begin
        if (rst) begin
            double_density_select_q <= 1'b0;
        end else if (load_density) begin
            double_density_select_q <= exec_cmd_q.double_density_select;
        end
    end
endmodule // fdcd_decoder

/* File: test/fdcd_decoder_asserts.sv */
// Port-level assertions for the command decoder.
// Assumes it is bound onto every fdcd_decoder instance.
`timescale 1ns/1ps
module fdcd_asserts
    import fdcd_pkg::*;
#(
    parameter logic [7:0] VERSION_CODE = VERSION_DEFAULT
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic host_wr,
    input wire logic [7:0] host_wdata,
    input wire logic host_rd,
    input wire logic [3:0][7:0] drive_status,
    input wire logic exec_done,
    input wire logic busy_q,
    input wire logic res_valid_q,
    input wire logic [7:0] res_data_q,
    input wire logic exec_req_q,
    input wire logic step_q
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Opcode taken in idle after a quiet cycle
    sequence s_op(logic [7:0] op);
        !busy_q && !$past(host_wr) && host_wr && host_wdata == op;
    endsequence
    property p_rst;
        $fell(rst) |-> !busy_q && !res_valid_q && !exec_req_q && !step_q;
    endproperty
    property p_version;
        s_op(OP_VERSION) |-> ##2 busy_q ##1 res_valid_q && res_data_q == VERSION_CODE;
    endproperty
    property p_invalid;
        s_op(8'h00) |-> ##3 res_valid_q && res_data_q == ST0_INVALID;
    endproperty
    property p_sdrv;
        logic [1:0] d;
        s_op(OP_SENSE_DRV) ##1 (host_wr, d = host_wdata[1:0])
            |-> ##3 res_valid_q && res_data_q == drive_status[d];
    endproperty
    property p_pop;
        res_valid_q && host_rd |=> !res_valid_q;
    endproperty
    property p_hold;
        res_valid_q && !host_rd |=> res_valid_q && $stable(res_data_q);
    endproperty
    property p_exec_hold;
        exec_req_q && !exec_done |=> exec_req_q;
    endproperty
    property p_exec_drop;
        exec_req_q && exec_done |=> !exec_req_q;
    endproperty
    property p_step;
        step_q |=> !step_q;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    a_version: assert property (p_version) else $error("version byte wrong");
    a_invalid: assert property (p_invalid) else $error("invalid opcode answer");
    a_sdrv: assert property (p_sdrv) else $error("drive status byte wrong");
    a_pop: assert property (p_pop) else $error("result not popped");
    a_hold: assert property (p_hold) else $error("result byte moved");
    a_exec_hold: assert property (p_exec_hold) else $error("request dropped");
    a_exec_drop: assert property (p_exec_drop) else $error("request stuck");
    a_step: assert property (p_step) else $error("step pulse too long");
endmodule // fdcd_asserts

bind fdcd_decoder fdcd_asserts #(.VERSION_CODE(VERSION_CODE)) fdcd_asserts_i (
    .core_clk(core_clk), .rst(rst), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_rd(host_rd), .drive_status(drive_status), .exec_done(exec_done),
    .busy_q(busy_q), .res_valid_q(res_valid_q), .res_data_q(res_data_q),
    .exec_req_q(exec_req_q), .step_q(step_q));

/* File: test/fdcd_exec_model.sv */
// Execution engine stand-in answering dispatched data commands.
// Assumes exec_req_q holds until exec_done has been seen.
`timescale 1ns/1ps
module fdcd_exec_model
    import fdcd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic exec_req_q,
    input wire fdcd_exec_type exec_cmd_q,
    input wire logic [3:0] lat,
    output logic exec_done,
    output fdcd_result_type exec_result
);
    // ---------
    // Responder
    // ---------
    logic [3:0] cnt_q = 4'h0;
    always @(posedge core_clk) begin
        exec_done <= 1'b0;
        cnt_q <= cnt_q + 4'h1;
        // Outside the answer cycle the bytes toggle so stale data never matches
        if (rst) begin
            exec_result <= '0;
        end else if (!exec_req_q || exec_done || cnt_q != lat) begin
            exec_result <= ~exec_result;
        end else begin
            exec_done <= 1'b1;
            for (int i = 0; i < 7; i++) exec_result.bytes[i] <= exec_cmd_q.param[i] + 8'(i);
        end
        if (rst || !exec_req_q || exec_done) cnt_q <= 4'h0;
    end
endmodule // fdcd_exec_model

/* File: test/tb_floppy_command_set_decoder.sv */
// Self-checking bench for the floppy command decoder.
// Assumes fdcd_exec_model answers the execution port.
`timescale 1ns/1ps
module tb_floppy_command_set_decoder
    import fdcd_pkg::*;
;
    // -----
    // Setup
    // -----
    localparam logic [7:0] VER = 8'h3c; // arbitrary value
    logic core_clk = 1'b0, rst = 1'b1, host_wr = 1'b0, host_rd = 1'b0, ext_rng = 1'b0;
    logic [7:0] host_wdata = 8'h00, res_data_q, r, b [9];
    logic [3:0][7:0] drive_status = '0;
    logic [3:0] lat = 4'h0;
    logic busy_q, res_valid_q, exec_req_q, exec_done, double_density_select_q;
    logic head_select_q, step_q, step_dir_q;
    logic [1:0] drive_sel_q;
    fdcd_exec_type exec_cmd_q;
    fdcd_result_type exec_result;
    fdcd_timing_type timing_q;
    int err_count = 0, tests_run = 0, n_in = 0, n_out = 0;
    logic [7:0] opc [5] = '{8'h1d, 8'h19, 8'h16, 8'h05, 8'h09};
    logic [7:0] msk [5] = '{8'he0, 8'he0, 8'he0, 8'hc0, 8'hc0};
    fdcd_kind_type knd [5] = '{K_SCAN_HE, K_SCAN_LE, K_VERIFY, K_WRITE, K_WRITE_DEL};
    always #4 core_clk = ~core_clk;
    always @(negedge core_clk) begin
        if (step_q === 1'b1 && step_dir_q === 1'b1) n_in++;
        if (step_q === 1'b1 && step_dir_q !== 1'b1) n_out++;
    end
    fdcd_decoder #(.STEP_UNIT_CYCLES(2), .VERSION_CODE(VER)) fdcd_decoder_i (
        .core_clk(core_clk), .rst(rst), .host_wr(host_wr), .host_wdata(host_wdata),
        .host_rd(host_rd), .extended_track_range(ext_rng), .drive_status(drive_status),
        .exec_done(exec_done), .exec_result(exec_result), .busy_q(busy_q),
        .res_valid_q(res_valid_q), .res_data_q(res_data_q), .exec_req_q(exec_req_q),
        .exec_cmd_q(exec_cmd_q), .double_density_select_q(double_density_select_q),
        .timing_q(timing_q), .drive_sel_q(drive_sel_q), .head_select_q(head_select_q),
        .step_q(step_q), .step_dir_q(step_dir_q));
    fdcd_exec_model fdcd_exec_model_i (.core_clk(core_clk), .rst(rst),
        .exec_req_q(exec_req_q), .exec_cmd_q(exec_cmd_q), .lat(lat),
        .exec_done(exec_done), .exec_result(exec_result));
    // -----
    // Tasks
    // -----
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (e !== g) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            host_wr = 1'b1;
            host_wdata = b[i];
            @(negedge core_clk);
        end
        host_wr = 1'b0;
    endtask
    task automatic cmd(input int n, input logic [31:0] w);
        for (int i = 0; i < 4; i++) b[i] = w[31-8*i -: 8];
        send(n);
    endtask
    task automatic get(input string nm, input logic [7:0] e);
        for (int k = 0; k < 400 && res_valid_q !== 1'b1; k++) @(negedge core_clk);
        chk(nm, {8'h01, e}, {7'h00, res_valid_q, res_data_q});
        host_rd = 1'b1;
        @(negedge core_clk);
        host_rd = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic quiet(input string nm);
        repeat (3) @(negedge core_clk);
        for (int k = 0; k < 3000 && busy_q !== 1'b0; k++) @(negedge core_clk);
        repeat (4) @(negedge core_clk);
        chk(nm, 16'h0000, {busy_q, res_valid_q});
    endtask
    function automatic logic [15:0] span(input logic [11:0] a, input logic [11:0] z);
        return 16'(a > z ? a - z : z - a);
    endfunction
    task automatic seek(input logic [11:0] t, input logic [11:0] from, input logic e);
        n_in = 0;
        n_out = 0;
        ext_rng = e;
        cmd(e ? 4 : 3, {OP_SEEK, 8'h05, t[7:0], t[11:8], 4'h0});
        quiet("seek result");
        chk("steps", span(t, from), 16'(t > from ? n_in : n_out));
        chk("wrong way", 16'h0, 16'(t > from ? n_out : n_in));
        cmd(1, {OP_SENSE_INT, 24'h0});
        get("seek st0", 8'h25);
        get("track", t[7:0]);
        if (e) get("nibble", {t[11:8], 4'h0});
        quiet("sense count");
        $display("test seek to %h done", t);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // -----
    // Tests
    // -----
    initial begin
        #400000;
        err_count++;
        finish_test();
    end
    initial begin
        void'($urandom(43284));
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        cmd(1, {OP_VERSION, 24'h0});
        get("version", VER);
        cmd(1, 32'h0);
        get("invalid", ST0_INVALID);
        cmd(1, {8'h8f, 24'h0});
        get("relative", ST0_INVALID);
        drive_status = $urandom;
        for (int d = 0; d < 4; d++) begin
            cmd(2, {OP_SENSE_DRV, 8'(d), 16'h0});
            get("drive status", drive_status[d]);
        end
        r = 8'($urandom);
        cmd(3, {OP_SPECIFY, 4'hf, r[3:0], r, 8'h0});
        quiet("specify");
        chk("timing", {4'hf, r[3:0], r}, timing_q);
        for (int h = 0; h < 2; h++) begin
            r = 8'($urandom);
            cmd(3, {8'h21, 8'(8'h33 + 4 * h), r, 8'h0});
            get("track write", r);
            cmd(3, {8'h61, 8'(8'h33 + 4 * h), 16'h0});
            get("track read", r);
        end
        cmd(1, {OP_SENSE_INT, 24'h0});
        get("no pending", ST0_INVALID);
        quiet("one byte");
        $display("test control commands done");
        seek(12'h009, 12'h000, 1'b0);
        seek(12'h10a, 12'h009, 1'b1);
        seek(12'h004, 12'h10a, 1'b1);
        for (int c = 0; c < 5; c++) begin
            r = 8'($urandom);
            lat = 4'($urandom_range(0, 7));
            for (int i = 1; i < 9; i++) b[i] = 8'($urandom);
            b[0] = opc[c] | (r & msk[c]);
            send(9);
            for (int k = 0; k < 20 && exec_req_q !== 1'b1; k++) @(negedge core_clk);
            chk("kind", 16'(knd[c]), 16'(exec_cmd_q.kind));
            chk("request", 16'h0001, 16'(exec_req_q));
            chk("sk", 16'(b[0][5]), 16'(exec_cmd_q.skip_deleted_flag));
            chk("mt", 16'(b[0][7]), 16'(exec_cmd_q.multi_track_flag));
            chk("density", 16'(b[0][6]), 16'(double_density_select_q));
            chk("drive", 16'(b[1][2:0]), 16'({head_select_q, drive_sel_q}));
            for (int i = 0; i < 7; i++) get("result", b[i+1] + 8'(i));
            $display("test data command %0d done", c);
        end
        finish_test();
    end
endmodule // tb_floppy_command_set_decoder
